/* hdl/isb_pkg.sv */
package isb_pkg;

    // ------------------------------------------------------------
    // Buffer geometry
    // ------------------------------------------------------------
    localparam int BUF_DEPTH = 200;
    localparam int IDX_W = 8;
    localparam logic [IDX_W-1:0] IDX_RESET = 8'h00;

    // ------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------
    localparam int STRAP_W = 3;
    localparam int FIXED_W = 4;
    localparam int ADDR_W = FIXED_W + STRAP_W;
    // Fixed upper address part; value is arbitrary
    localparam logic [FIXED_W-1:0] ADDR_FIXED_DEF = 4'h5;
    localparam int DIR_BIT = 0;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_SEL_MIN = 8'h01;
    localparam logic [7:0] CMD_SEL_MAX = 8'h0F;
    localparam logic [7:0] CMD_CLR_INT = 8'hF1;
    localparam int SEL_W = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_FREQ_KHZ = 200000;
    localparam longint SCL_MAX_KHZ = 400;
    localparam longint STRETCH_NS = 100;
    // Least time, so round up to whole cycles
    localparam int STRETCH_CYC =
        int'((STRETCH_NS * CLK_FREQ_KHZ + 64'd999999) / 64'd1000000);
    // Core cycles per bus clock at the top rate, for reference
    localparam int SCL_PERIOD_CYC = int'(CLK_FREQ_KHZ / SCL_MAX_KHZ);
    localparam int STR_W = 8;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [IDX_W-1:0] len;
    } isb_cmd_t;

    typedef struct packed {
        logic en;
        logic [IDX_W-1:0] idx;
        logic [7:0] data;
    } isb_buf_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK
    } isb_state_t;

endpackage

/* hdl/isb_slave.sv */
`timescale 1ns/10ps
module isb_slave
    import isb_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH,
    parameter logic [FIXED_W-1:0] ADDR_FIXED = ADDR_FIXED_DEF
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Two-wire bus, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Address straps
    input wire logic addr_strap_bit_low_in,
    input wire logic addr_strap_bit_mid_in,
    input wire logic addr_strap_bit_high_in,
    // Interrupt, open drain, active low
    output logic int_n_out,
    output logic int_oe_out,
    // Select lines, bit 0 is select_line_zero
    input wire logic [SEL_W-1:0] select_line_gpio_in,
    input wire logic [SEL_W-1:0] gpio_level_in,
    input wire logic [SEL_W-1:0] gpio_oe_in,
    output logic [SEL_W-1:0] select_line_n_out,
    output logic [SEL_W-1:0] select_line_oe_out,
    // Command executor side
    output isb_cmd_t cmd_out,
    input wire logic exec_done_in,
    input wire logic spi_done_in,
    input wire isb_buf_wr_t exec_wr_in,
    input wire logic [IDX_W-1:0] exec_rd_idx_in,
    output logic [7:0] exec_rd_data_out,
    output logic busy_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);
    localparam logic [IDX_W-1:0] FULL_CNT = IDX_W'(DEPTH);
    localparam logic [STR_W-1:0] STRETCH_LD = STR_W'(STRETCH_CYC);

    logic [7:0] buf_q [DEPTH];
    logic [STRAP_W-1:0] strap_q;
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    isb_state_t state_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic is_read_q, wr_sess_q, have_cmd_q, ack_drv_q, mack_q;
    logic [7:0] cmd_q;
    logic [IDX_W-1:0] wr_cnt_q, rd_ptr_q;
    logic [STR_W-1:0] stretch_q;
    logic busy_q, int_q;
    logic rx_wr;
    logic [ADDR_W-1:0] own_addr;
    logic addr_hit, launch, sel_cmd;

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    // Reset is synchronous, so sampling the pins here is a clocked capture
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            strap_q <= {addr_strap_bit_high_in, addr_strap_bit_mid_in,
                        addr_strap_bit_low_in};
        end
    end

    assign own_addr = {ADDR_FIXED, strap_q};

    // ------------------------------------------------------------
    // Bus condition detection
    // ------------------------------------------------------------
    // Pins are synchronous; one stage of history gives the edges
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    assign start_det = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_det = scl_in & scl_q & ~sda_q & sda_in;

    // Address byte sits in shift_q after eight bits
    assign addr_hit = (shift_q[7:1] == own_addr);
    // A finished write message with a command hands over at STOP
    assign launch = stop_det & wr_sess_q & have_cmd_q;

    // ------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------
    // Core clock is 500x the top bus rate, so every bit is seen
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            is_read_q <= 1'b0;
            wr_sess_q <= 1'b0;
            have_cmd_q <= 1'b0;
            cmd_q <= 8'h00;
            wr_cnt_q <= IDX_RESET;
            rd_ptr_q <= IDX_RESET;
            ack_drv_q <= 1'b0;
            mack_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
            ack_drv_q <= 1'b0;
            wr_sess_q <= 1'b0;
            have_cmd_q <= 1'b0;
        end else if (start_det) begin
            // Repeated START also restarts address reception
            state_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            ack_drv_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_in};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_q <= 4'h0;
                        state_q <= ST_ACK;
                        if (state_q == ST_ADDR) begin
                            if (addr_hit && !busy_q) begin
                                ack_drv_q <= 1'b1;
                                is_read_q <= shift_q[DIR_BIT];
                                wr_sess_q <= ~shift_q[DIR_BIT];
                                have_cmd_q <= 1'b0;
                                wr_cnt_q <= IDX_RESET;
                                rd_ptr_q <= IDX_RESET;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else if (!have_cmd_q) begin
                            cmd_q <= shift_q;
                            have_cmd_q <= 1'b1;
                            ack_drv_q <= 1'b1;
                        end else if (wr_cnt_q != FULL_CNT) begin
                            wr_cnt_q <= wr_cnt_q + 1'b1;
                            ack_drv_q <= 1'b1;
                        end
                        // Otherwise no acknowledge: byte dropped
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        ack_drv_q <= 1'b0;
                        if (is_read_q) begin
                            shift_q <= buf_q[rd_ptr_q];
                            rd_ptr_q <= (rd_ptr_q == LAST_IDX) ?
                                IDX_RESET : rd_ptr_q + 1'b1;
                            state_q <= ST_TX;
                        end else begin
                            state_q <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        shift_q <= {shift_q[6:0], 1'b0};
                        if (bit_cnt_q == 4'h7) begin
                            bit_cnt_q <= 4'h0;
                            state_q <= ST_TXACK;
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        mack_q <= ~sda_in;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            // Master wants more: next byte in order
                            shift_q <= buf_q[rd_ptr_q];
                            rd_ptr_q <= (rd_ptr_q == LAST_IDX) ?
                                IDX_RESET : rd_ptr_q + 1'b1;
                            state_q <= ST_TX;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Store point for an accepted data byte
    assign rx_wr = (state_q == ST_RX) && !start_det && !stop_det &&
        scl_fall && (bit_cnt_q == 4'h8) && have_cmd_q &&
        (wr_cnt_q != FULL_CNT);

    // ------------------------------------------------------------
    // Clock stretching
    // ------------------------------------------------------------
    // Hold SCL low after each acknowledge slot while the next byte is
    // prepared; only ever pulls low, never drives the clock itself
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            stretch_q <= '0;
        end else if (stop_det || start_det) begin
            stretch_q <= '0;
        end else if (scl_fall &&
                     (state_q == ST_ACK || state_q == ST_TXACK)) begin
            stretch_q <= STRETCH_LD;
        end else if (stretch_q != '0) begin
            stretch_q <= stretch_q - 1'b1;
        end
    end

    assign scl_out = 1'b0;
    assign scl_oe_out = (stretch_q != '0);
    assign sda_out = 1'b0;
    // Open drain: drive low for ACK or for a zero data bit
    assign sda_oe_out = ack_drv_q |
        ((state_q == ST_TX) & ~shift_q[7]);

    // ------------------------------------------------------------
    // Shared data buffer
    // ------------------------------------------------------------
    // Host writes only land while idle; executor writes are taken at any time,
    // busy or not, so both can meet in one cycle; the bus side wins regardless
    always_ff @(posedge core_clk_in) begin
        if (rx_wr) begin
            buf_q[wr_cnt_q] <= shift_q;
        end else if (exec_wr_in.en && exec_wr_in.idx < FULL_CNT) begin
            buf_q[exec_wr_in.idx] <= exec_wr_in.data;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            exec_rd_data_out <= 8'h00;
        end else if (exec_rd_idx_in < FULL_CNT) begin
            exec_rd_data_out <= buf_q[exec_rd_idx_in];
        end else begin
            exec_rd_data_out <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Command hand-over and busy
    // ------------------------------------------------------------
    // Clear-interrupt is done locally and never makes the block busy
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
            cmd_out <= '0;
        end else begin
            cmd_out.valid <= 1'b0;
            if (launch && cmd_q != CMD_CLR_INT) begin
                busy_q <= 1'b1;
                cmd_out.valid <= 1'b1;
                cmd_out.code <= cmd_q;
                cmd_out.len <= wr_cnt_q;
            end else if (exec_done_in) begin
                busy_q <= 1'b0;
            end
        end
    end

    assign busy_out = busy_q;

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    // A completion in the same cycle as the clear keeps the flag set
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            int_q <= 1'b0;
        end else if (spi_done_in) begin
            int_q <= 1'b1;
        end else if (launch && cmd_q == CMD_CLR_INT) begin
            int_q <= 1'b0;
        end
    end

    assign int_n_out = 1'b0;
    assign int_oe_out = int_q;

    // ------------------------------------------------------------
    // Select lines
    // ------------------------------------------------------------
    // Selects not in GPIO mode assert only while an SPI command runs; several may be
    // active at once, contention on the far side is the user's concern
    assign sel_cmd = busy_q && cmd_q >= CMD_SEL_MIN &&
        cmd_q <= CMD_SEL_MAX;

    always_comb begin
        for (int i = 0; i < SEL_W; i++) begin
            if (select_line_gpio_in[i]) begin
                select_line_n_out[i] = gpio_level_in[i];
                select_line_oe_out[i] = gpio_oe_in[i];
            end else begin
                select_line_n_out[i] = ~(sel_cmd & cmd_q[i]);
                select_line_oe_out[i] = 1'b1;
            end
        end
    end

endmodule

/* dv/isb_slave_sva.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the serial slave
// ----------------------------------------
module isb_slave_chk
    import isb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Open-drain pins
    input wire logic scl_out,
    input wire logic scl_oe_out,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic int_n_out,
    input wire logic int_oe_out,
    // Select lines
    input wire logic [SEL_W-1:0] select_line_gpio_in,
    input wire logic [SEL_W-1:0] gpio_level_in,
    input wire logic [SEL_W-1:0] gpio_oe_in,
    input wire logic [SEL_W-1:0] select_line_n_out,
    input wire logic [SEL_W-1:0] select_line_oe_out,
    // Executor side
    input wire isb_cmd_t cmd_out,
    input wire logic exec_done_in,
    input wire logic spi_done_in,
    input wire logic [IDX_W-1:0] exec_rd_idx_in,
    input wire logic [7:0] exec_rd_data_out,
    input wire logic busy_out
);
    logic [STR_W-1:0] str_q;
    logic [7:0] code_q;
    // Length of the running stretch, so its end can be checked exactly
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            str_q <= '0;
        end else begin
            str_q <= scl_oe_out ? str_q + 1'b1 : '0;
        end
    end
    // Last launched code, held for the select check
    always_ff @(posedge core_clk_in) begin
        if (cmd_out.valid) begin
            code_q <= cmd_out.code;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_od;
        scl_out == 1'b0 && sda_out == 1'b0 && int_n_out == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("pin drives high");
    property p_int;
        spi_done_in |=> int_oe_out;
    endproperty
    a_int: assert property (p_int) else $error("no interrupt");
    property p_busy_on;
        cmd_out.valid && cmd_out.code != CMD_CLR_INT |-> ##[0:1] busy_out;
    endproperty
    a_busy_on: assert property (p_busy_on) else $error("not busy");
    property p_busy_off;
        exec_done_in && busy_out && !cmd_out.valid |=> !busy_out;
    endproperty
    a_busy_off: assert property (p_busy_off) else $error("stuck");
    property p_busy_nack;
        busy_out |-> !$rose(sda_oe_out);
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("ack busy");
    property p_stretch;
        $fell(scl_oe_out) |-> str_q == STRETCH_CYC;
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch");
    property p_len;
        cmd_out.valid |-> cmd_out.len <= BUF_DEPTH;
    endproperty
    a_len: assert property (p_len) else $error("length over");
    property p_sel;
        cmd_out.valid && cmd_out.code >= CMD_SEL_MIN
            && cmd_out.code <= CMD_SEL_MAX && select_line_gpio_in == '0
            |=> select_line_n_out == ~code_q[3:0];
    endproperty
    a_sel: assert property (p_sel) else $error("select lines");
    property p_gpio;
        (select_line_n_out & select_line_gpio_in)
            == (gpio_level_in & select_line_gpio_in)
            && (select_line_oe_out | select_line_gpio_in) == '1;
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio mode");
    property p_oob;
        exec_rd_idx_in >= BUF_DEPTH |=> exec_rd_data_out == 8'h00;
    endproperty
    a_oob: assert property (p_oob) else $error("read beyond");
    c_cmd: cover property (cmd_out.valid);
    c_str: cover property ($fell(scl_oe_out));
    c_int: cover property ($rose(int_oe_out));
endmodule

bind isb_slave isb_slave_chk u_chk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .int_n_out(int_n_out),
    .int_oe_out(int_oe_out), .select_line_gpio_in(select_line_gpio_in),
    .gpio_level_in(gpio_level_in), .gpio_oe_in(gpio_oe_in),
    .select_line_n_out(select_line_n_out),
    .select_line_oe_out(select_line_oe_out), .cmd_out(cmd_out),
    .exec_done_in(exec_done_in), .spi_done_in(spi_done_in),
    .exec_rd_idx_in(exec_rd_idx_in),
    .exec_rd_data_out(exec_rd_data_out), .busy_out(busy_out)
);

/* dv/isb_bus_master.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Two-wire bus master model
// ----------------------------------------
module isb_bus_master #(
    parameter int Q = 12
) (
    // Clock and slave pull-downs
    input wire logic clk_in,
    input wire logic scl_oe_in,
    input wire logic sda_oe_in,
    // Resolved lines
    output wire logic scl_out,
    output wire logic sda_out
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    // Pulled-up lines: whoever pulls low wins
    assign scl_out = scl_q & ~scl_oe_in;
    assign sda_out = sda_q & ~sda_oe_in;
    task automatic w(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // Release clock and wait out a stretch, bounded so a hang shows
    task automatic rise();
        scl_q = 1'b1;
        for (int i = 0; i < 80 && !scl_out; i++) @(negedge clk_in);
        w(Q);
    endtask
    // Data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        w(1);
        sda_q = b;
        w(Q);
        rise();
        r = sda_out;
        scl_q = 1'b0;
    endtask
    task automatic start();
        w(1);
        sda_q = 1'b1;
        w(Q);
        rise();
        sda_q = 1'b0;
        w(Q);
        scl_q = 1'b0;
    endtask
    task automatic stop();
        w(1);
        sda_q = 1'b0;
        w(Q);
        rise();
        sda_q = 1'b1;
        w(Q);
    endtask
    // Byte out, MSB first, then sample acknowledge
    task automatic put(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // Byte in; low in the ninth slot asks for more
    task automatic get(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule

/* dv/i2c_slave_buffer_intake_bench.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Bench for the serial slave
// ----------------------------------------
module i2c_slave_buffer_intake_bench;
    import isb_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] s;
    logic [2:0] strap;
    logic [SEL_W-1:0] gsel = '0;
    logic [SEL_W-1:0] glev = '0;
    logic [SEL_W-1:0] goe = '0;
    logic done = 1'b0;
    logic spi = 1'b0;
    logic [IDX_W-1:0] ridx = '0;
    isb_buf_wr_t ew = '0;
    wire logic scl;
    wire logic sda;
    logic scl_oe, sda_oe, int_n, int_oe, busy, a;
    logic [SEL_W-1:0] sel_n, sel_oe;
    logic [7:0] rdat, d, last_code, last_len;
    isb_cmd_t cmd;
    int seed = 38922;
    int bad_count = 0;
    int num_checks = 0;
    int n_cmd = 0;
    int mdl [BUF_DEPTH];
    always #2.5 clk = ~clk;
    isb_bus_master m (.clk_in(clk), .scl_oe_in(scl_oe),
        .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
    isb_slave dut (.core_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl),
        .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(),
        .sda_oe_out(sda_oe), .addr_strap_bit_low_in(strap[0]),
        .addr_strap_bit_mid_in(strap[1]),
        .addr_strap_bit_high_in(strap[2]), .int_n_out(int_n),
        .int_oe_out(int_oe), .select_line_gpio_in(gsel),
        .gpio_level_in(glev), .gpio_oe_in(goe),
        .select_line_n_out(sel_n), .select_line_oe_out(sel_oe),
        .cmd_out(cmd), .exec_done_in(done), .spi_done_in(spi),
        .exec_wr_in(ew), .exec_rd_idx_in(ridx),
        .exec_rd_data_out(rdat), .busy_out(busy));
    // Record each launch; the pulse lasts one cycle only
    always @(posedge clk) begin
        if (cmd.valid === 1'b1) begin
            n_cmd <= n_cmd + 1;
            last_code <= cmd.code;
            last_len <= cmd.len;
        end
    end
    task automatic chk(input string nm, input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic hail(input logic [2:0] ad, input logic rd, exp);
        m.start();
        m.put({ADDR_FIXED_DEF, ad, rd}, a);
        chk("addr_ack", a, exp);
    endtask
    // One write message against the model, then executor handshake
    task automatic run_cmd(input logic [7:0] code, input int n);
        int k;
        int v;
        k = n_cmd;
        hail(s, 1'b0, 1'b1);
        m.put(code, a);
        chk("cmd_ack", a, 1'b1);
        for (int i = 0; i < n; i++) begin
            v = $random(seed) & 255;
            m.put(8'(v), a);
            chk("data_ack", a, 16'(i < BUF_DEPTH));
            if (i < BUF_DEPTH) mdl[i] = v;
        end
        m.stop();
        m.w(4);
        if (code == CMD_CLR_INT) begin
            chk("clr_launch", 16'(n_cmd), 16'(k));
            chk("clr_busy", busy, 1'b0);
            return;
        end
        chk("cmd_count", 16'(n_cmd), 16'(k + 1));
        chk("cmd_code", last_code, code);
        chk("cmd_len", last_len, 16'(n < 200 ? n : 200));
        chk("busy", busy, 1'b1);
        // Cast keeps the inversion at select width, not checker width
        if (code <= CMD_SEL_MAX) chk("sel", sel_n, SEL_W'(~code[3:0]));
        for (int i = 0; i <= n && i <= BUF_DEPTH; i++) begin
            ridx = (i < n && i < BUF_DEPTH) ? 8'(i) : 8'hC8;
            @(negedge clk);
            if (ridx == 8'hC8) chk("buf_end", rdat, 16'h0000);
            else chk("buf", rdat, 16'(mdl[i]));
        end
        hail(s, 1'b0, 1'b0);
        m.stop();
        @(negedge clk) done = 1'b1;
        @(negedge clk) done = 1'b0;
        chk("idle", busy, 1'b0);
    endtask
    initial begin
        s = 3'($random(seed));
        strap = s;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        strap = ~s;
        m.w(4);
        run_cmd(8'h0C, 201);
        $display("test long write done");
        for (int c = 1; c <= 15; c++) run_cmd(8'(c), c % 3);
        $display("test select codes done");
        hail(~s, 1'b0, 1'b0);
        m.stop();
        $display("test foreign address done");
        // Executor write lands in the shared buffer and reads back
        @(negedge clk) ew = '{1'b1, 8'h01, 8'($random(seed))};
        mdl[1] = ew.data;
        @(negedge clk) ew.en = 1'b0;
        // Read twice: contents come back in order and stay put
        for (int r = 0; r < 2; r++) begin
            hail(s, 1'b1, 1'b1);
            for (int i = 0; i < 4; i++) begin
                m.get(i < 3, d);
                chk("rd_data", d, 16'(mdl[i]));
            end
            m.stop();
        end
        $display("test read done");
        @(negedge clk) spi = 1'b1;
        @(negedge clk) spi = 1'b0;
        chk("int_on", {int_oe, int_n}, 2'b10);
        run_cmd(CMD_CLR_INT, 0);
        chk("int_off", int_oe, 1'b0);
        $display("test interrupt done");
        for (int k = 0; k < 6; k++) begin
            gsel = 4'($random(seed));
            glev = 4'($random(seed));
            goe = 4'($random(seed));
            @(negedge clk);
            chk("gpio_lvl", sel_n, SEL_W'((glev & gsel) | ~gsel));
            chk("gpio_oe", sel_oe, SEL_W'((goe & gsel) | ~gsel));
        end
        $display("test gpio done");
        report_and_stop();
    end
    // Watchdog well above the expected run length
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
endmodule
